// ==== common/dtc_pkg.sv ====
// package of constants for the dual-channel temperature conversion controller
package dtc_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ             = 10000000;   // reference clock rate
  localparam int INTEG_TIME_MS      = 60;         // per-channel integration window
  localparam int CYCLE_TIME_MS      = 125;        // whole two-channel cycle
  localparam int INTEG_CYCLES       = CLK_HZ / 1000 * INTEG_TIME_MS;
  localparam int CYCLE_CYCLES       = CLK_HZ / 1000 * CYCLE_TIME_MS;
  localparam int SETTLE_CYCLES_DFLT = (CYCLE_CYCLES - 2 * INTEG_CYCLES) / 2;
  // ---------------------------------------------------------------
  // data layout
  // ---------------------------------------------------------------
  localparam int TEMP_W    = 8;                   // result width
  localparam int ADC_W     = 9;                   // half-degree raw code width
  localparam int CNT_W     = 24;                  // cycle counter width
  localparam logic [7:0] TEMP_RST = 8'h00;        // reset value of results
  localparam logic [7:0] HI_RST   = 8'h7f;        // reset value of high limits
  localparam logic [7:0] LO_RST   = 8'hc9;        // reset value of low limits
  localparam logic [1:0] CH_REMOTE = 2'h1;        // mux select, remote diode
  localparam logic [1:0] CH_LOCAL  = 2'h2;        // mux select, local diode
  localparam logic [1:0] CH_NONE   = 2'h0;        // bias off
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DTC_IDLE,
    DTC_SETTLE_R,
    DTC_CONV_R,
    DTC_SETTLE_L,
    DTC_CONV_L,
    DTC_LOAD
  } dtc_state_e;
endpackage

// ==== design/dtc_core.sv ====
// conversion sequencer, result registers and alarm compare of the thermometer
`timescale 1ns/100ps
// Notes on behaviour
// - latch address select pins once after reset
// - sleep input low means standby, high operate
// - hardware standby keeps results and thresholds unchanged; a one-shot in software standby loads results
// - alert only pulls low or releases
// - data line open drain, clock input only
// - each conversion yields eight bits per channel
// - two result registers compared with four limits
// - each channel integrates for sixty milliseconds
// - bias steered remote then local each cycle
// - started cycle converts both channels
// - both channels always measured
// - start by command or auto timer
// - busy set only while cycle runs
// - results hold previous values during conversion
// - hardware standby, or a rise of software standby, aborts cycle without updating results
// - one-shot ignored in hardware standby only
// - twos complement degrees, half-degree rounding
// - full cycle lasts about 125 ms
module dtc_core #(
  parameter int SETTLE_CYCLES = dtc_pkg::SETTLE_CYCLES_DFLT, // gap before each integration
  parameter int INTEG_CYC     = dtc_pkg::INTEG_CYCLES         // integration length
) (
  // clock and reset
  input  wire logic       I_REF_CLK,
  input  wire logic       I_SYS_RST,
  // pins
  input  wire logic       I_ADDR_SELECT_LOW_PIN,
  input  wire logic       I_ADDR_SELECT_HIGH_PIN,
  input  wire logic       I_HW_SLEEP_INPUT_N,
  input  wire logic       I_SERIAL_CLOCK_LINE,
  input  wire logic       I_SERIAL_DATA_LINE,
  output logic            O_SERIAL_DATA_LINE,
  output logic            O_SERIAL_DATA_LINE_OE,
  output logic            O_ALERT_N,
  output logic            O_ALERT_N_OE,
  // control from the serial front end (same clock)
  input  wire logic       I_SW_STANDBY,
  input  wire logic       I_ONE_SHOT,
  input  wire logic       I_AUTO_START,
  input  wire logic       I_SDA_PULL,
  input  wire logic       I_LIMIT_WE,
  input  wire logic [1:0] I_LIMIT_SEL,
  input  wire logic [7:0] I_LIMIT_DATA,
  // analog front end (same clock)
  input  wire logic [8:0] I_ADC_CODE,
  output logic [1:0]      O_BIAS_SEL,
  // status and results
  output logic [1:0]      O_ADDR_STRAP,
  output logic            O_BUSY,
  output logic            O_STANDBY,
  output logic [7:0]      O_TEMP_REMOTE,
  output logic [7:0]      O_TEMP_LOCAL,
  output logic [3:0]      O_ALARM_FLAGS,
  output logic [1:0]      O_SCL_SYNC_SDA_SYNC
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // raw code is half-degree twos complement; add half a degree, drop lsb
  function automatic logic [7:0] round_code(input logic [8:0] raw);
    logic [9:0] sum;
    sum = {raw[8], raw} + 10'h001;
    if (sum[9] != sum[8])
      return sum[9] ? 8'h80 : 8'h7f;  // clamp on overflow
    return sum[8:1];
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] sync1;          // first stage, read only by second
  logic [3:0] sync2;          // second stage
  logic       strap_taken;    // strap capture done
  logic       hw_sleep;       // synchronised standby request

  // two flops on every pin input
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      // idle levels: both serial lines high, sleep pin in operate, so no
      // false standby is seen in the first cycles after reset
      sync1 <= 4'he;
      sync2 <= 4'he;
    end else begin
      sync1 <= {I_SERIAL_DATA_LINE, I_SERIAL_CLOCK_LINE, I_HW_SLEEP_INPUT_N,
                I_ADDR_SELECT_HIGH_PIN ^ I_ADDR_SELECT_LOW_PIN ^ I_ADDR_SELECT_LOW_PIN};
      sync2 <= sync1;
    end
  end

  logic [1:0] strap_s1;       // address pins, first stage
  logic [1:0] strap_s2;       // address pins, second stage
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      strap_s1 <= 2'h0;
      strap_s2 <= 2'h0;
    end else begin
      strap_s1 <= {I_ADDR_SELECT_HIGH_PIN, I_ADDR_SELECT_LOW_PIN};
      strap_s2 <= strap_s1;
    end
  end

  assign hw_sleep = ~sync2[1];  // low level means standby

  // ---------------------------------------------------------------
  // address strap capture
  // ---------------------------------------------------------------
  // take the pins once, after the synchroniser has filled
  logic [1:0] strap_wait;     // fill delay after reset
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      strap_wait   <= 2'h0;
      strap_taken  <= 1'b0;
      O_ADDR_STRAP <= 2'h0;
    end else if (!strap_taken) begin
      if (strap_wait == 2'h3) begin
        O_ADDR_STRAP <= strap_s2;   // later pin changes ignored
        strap_taken  <= 1'b1;
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // serial pin drivers
  // ---------------------------------------------------------------
  // data line only pulls low; clock line is never driven
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_SERIAL_DATA_LINE    <= 1'b0;
      O_SERIAL_DATA_LINE_OE <= 1'b0;
      O_SCL_SYNC_SDA_SYNC   <= 2'h3;
    end else begin
      O_SERIAL_DATA_LINE    <= 1'b0;          // drive value fixed low
      O_SERIAL_DATA_LINE_OE <= I_SDA_PULL;    // release or pull low
      O_SCL_SYNC_SDA_SYNC   <= sync2[3:2];    // sampled clock and data
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  dtc_pkg::dtc_state_e state;       // current step
  logic [dtc_pkg::CNT_W-1:0] cnt;   // step timer
  logic [7:0] res_remote;           // remote result held until load

  logic standby;                    // either standby source
  logic start_req;                  // a start is accepted this cycle
  assign standby   = hw_sleep | I_SW_STANDBY;
  // one-shot works in software standby, not hardware
  assign start_req = (I_ONE_SHOT & ~hw_sleep) | (I_AUTO_START & ~standby);

  logic sw_hw_sleep_input_q;                  // software standby, one cycle late
  logic abort;                      // running cycle is cut this cycle
  // software standby cuts a cycle only on its rising edge, so a one-shot
  // issued while software standby is held still runs to the end
  assign abort = (state != dtc_pkg::DTC_IDLE) &&
                 (hw_sleep || (I_SW_STANDBY && !sw_hw_sleep_input_q));

  // remembers the software standby level so that its rise can be seen
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      sw_hw_sleep_input_q <= 1'b0;
    end else begin
      sw_hw_sleep_input_q <= I_SW_STANDBY;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      state      <= dtc_pkg::DTC_IDLE;
      cnt        <= '0;
      res_remote <= dtc_pkg::TEMP_RST;
    end else if (abort) begin
      // either standby source truncates; nothing is latched
      state <= dtc_pkg::DTC_IDLE;
      cnt   <= '0;
    end else begin
      case (state)
        dtc_pkg::DTC_IDLE: begin
          cnt <= '0;
          if (start_req)
            state <= dtc_pkg::DTC_SETTLE_R;
        end
        dtc_pkg::DTC_SETTLE_R: begin
          if (cnt == dtc_pkg::CNT_W'(SETTLE_CYCLES - 1)) begin
            cnt   <= '0;
            state <= dtc_pkg::DTC_CONV_R;
          end else
            cnt <= cnt + 1'b1;
        end
        dtc_pkg::DTC_CONV_R: begin
          if (cnt == dtc_pkg::CNT_W'(INTEG_CYC - 1)) begin
            cnt        <= '0;
            res_remote <= round_code(I_ADC_CODE);
            state      <= dtc_pkg::DTC_SETTLE_L;       // local always follows
          end else
            cnt <= cnt + 1'b1;
        end
        dtc_pkg::DTC_SETTLE_L: begin
          if (cnt == dtc_pkg::CNT_W'(SETTLE_CYCLES - 1)) begin
            cnt   <= '0;
            state <= dtc_pkg::DTC_CONV_L;
          end else
            cnt <= cnt + 1'b1;
        end
        dtc_pkg::DTC_CONV_L: begin
          if (cnt == dtc_pkg::CNT_W'(INTEG_CYC - 1)) begin
            cnt   <= '0;
            state <= dtc_pkg::DTC_LOAD;                // both channels done
          end else
            cnt <= cnt + 1'b1;
        end
        dtc_pkg::DTC_LOAD: begin
          state <= dtc_pkg::DTC_IDLE;
        end
        default: begin
          state <= dtc_pkg::DTC_IDLE;
          cnt   <= '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // mux steering, busy and standby status
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_BIAS_SEL <= dtc_pkg::CH_NONE;
      O_BUSY     <= 1'b0;
      O_STANDBY  <= 1'b0;
    end else begin
      O_STANDBY <= standby;
      // bias turns on with busy and off as soon as a cycle is cut
      if (abort) begin
        O_BIAS_SEL <= dtc_pkg::CH_NONE;                // cut cycle, bias off
      end else begin
        case (state)
          dtc_pkg::DTC_IDLE: begin
            O_BIAS_SEL <= start_req ? dtc_pkg::CH_REMOTE : dtc_pkg::CH_NONE;
          end
          dtc_pkg::DTC_SETTLE_R, dtc_pkg::DTC_CONV_R: O_BIAS_SEL <= dtc_pkg::CH_REMOTE;
          dtc_pkg::DTC_SETTLE_L, dtc_pkg::DTC_CONV_L: O_BIAS_SEL <= dtc_pkg::CH_LOCAL;
          default:                                    O_BIAS_SEL <= dtc_pkg::CH_NONE;
        endcase
      end
      // busy from start through load, dropped on abort
      O_BUSY <= (state == dtc_pkg::DTC_IDLE) ? start_req
              : (state != dtc_pkg::DTC_LOAD) && !abort;
    end
  end

  // ---------------------------------------------------------------
  // result and limit registers
  // ---------------------------------------------------------------
  logic [7:0] lim [4];        // remote hi, remote lo, local hi, local lo

  // results change only on a completed load
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_TEMP_REMOTE <= dtc_pkg::TEMP_RST;
      O_TEMP_LOCAL  <= dtc_pkg::TEMP_RST;
    end else if (state == dtc_pkg::DTC_LOAD && !abort) begin
      O_TEMP_REMOTE <= res_remote;                     // both together
      O_TEMP_LOCAL  <= round_code(I_ADC_CODE);
    end
  end

  // limits written only by the host, never by standby
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      lim[0] <= dtc_pkg::HI_RST;
      lim[1] <= dtc_pkg::LO_RST;
      lim[2] <= dtc_pkg::HI_RST;
      lim[3] <= dtc_pkg::LO_RST;
    end else if (I_LIMIT_WE) begin
      lim[I_LIMIT_SEL] <= I_LIMIT_DATA;
    end
  end

  // ---------------------------------------------------------------
  // alarm compare and alert pin
  // ---------------------------------------------------------------
  // signed compare against four limits on every clock
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_ALARM_FLAGS <= 4'h0;
    end else begin
      O_ALARM_FLAGS <= {$signed(O_TEMP_LOCAL)  < $signed(lim[3]),
                        $signed(O_TEMP_LOCAL)  > $signed(lim[2]),
                        $signed(O_TEMP_REMOTE) < $signed(lim[1]),
                        $signed(O_TEMP_REMOTE) > $signed(lim[0])};
    end
  end

  // open drain: output value always low, enable pulls
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_ALERT_N    <= 1'b0;
      O_ALERT_N_OE <= 1'b0;
    end else begin
      O_ALERT_N    <= 1'b0;
      O_ALERT_N_OE <= |O_ALARM_FLAGS;
    end
  end
endmodule

// ==== tb/dtc_core_checker.sv ====
// port assertions for the conversion controller
`timescale 1ns/100ps
module dtc_core_checker (
  // clock and reset
  input wire logic       I_REF_CLK,
  input wire logic       I_SYS_RST,
  // watched pins and controls
  input wire logic       I_HW_SLEEP_INPUT_N,
  input wire logic       I_SW_STANDBY,
  input wire logic       I_ONE_SHOT,
  input wire logic       I_SDA_PULL,
  input wire logic       O_SERIAL_DATA_LINE,
  input wire logic       O_SERIAL_DATA_LINE_OE,
  input wire logic       O_ALERT_N,
  input wire logic       O_ALERT_N_OE,
  input wire logic [1:0] O_BIAS_SEL,
  input wire logic [1:0] O_ADDR_STRAP,
  input wire logic       O_BUSY,
  input wire logic       O_STANDBY,
  input wire logic [7:0] O_TEMP_REMOTE,
  input wire logic [7:0] O_TEMP_LOCAL,
  input wire logic [3:0] O_ALARM_FLAGS
);
  // ---------------------------------------------------------------
  // cycles since reset, saturating
  // ---------------------------------------------------------------
  logic [3:0] since_rst;
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      since_rst <= 4'h0;
    end else if (since_rst != 4'hf) begin
      since_rst <= since_rst + 4'h1;
    end
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  strap_held_a: assert property (since_rst == 4'hf |-> $stable(O_ADDR_STRAP))
    else $error("strap moved");
  alert_low_only_a: assert property (O_ALERT_N == 1'b0)
    else $error("alert driven high");
  sda_low_only_a: assert property (since_rst != 4'h0 |->
    O_SERIAL_DATA_LINE == 1'b0 && O_SERIAL_DATA_LINE_OE == $past(I_SDA_PULL))
    else $error("data line drive");
  alert_follow_a: assert property (since_rst != 4'h0 |->
    O_ALERT_N_OE == (|$past(O_ALARM_FLAGS))) else $error("alert not tied to flags");
  start_taken_a: assert property (I_HW_SLEEP_INPUT_N [*4] ##0 (!O_BUSY && I_ONE_SHOT)
    |=> O_BUSY) else $error("start lost");
  hw_refuse_a: assert property (!I_HW_SLEEP_INPUT_N [*4] ##0 !O_BUSY |=> !O_BUSY)
    else $error("start in standby");
  results_hold_a: assert property (O_BUSY && $past(O_BUSY) |->
    $stable(O_TEMP_REMOTE) && $stable(O_TEMP_LOCAL)) else $error("result moved in cycle");
  load_at_end_a: assert property ($changed(O_TEMP_REMOTE) || $changed(O_TEMP_LOCAL)
    |-> $fell(O_BUSY)) else $error("result load off cycle end");
  standby_keep_a: assert property (O_STANDBY && !I_SW_STANDBY && !O_BUSY
    |=> $stable(O_TEMP_REMOTE) && $stable(O_TEMP_LOCAL)) else $error("standby lost data");
  bias_remote_a: assert property ($rose(O_BUSY) |-> O_BIAS_SEL == dtc_pkg::CH_REMOTE)
    else $error("bias not remote first");
  bias_idle_a: assert property (!O_BUSY |-> O_BIAS_SEL == dtc_pkg::CH_NONE)
    else $error("bias on while idle");
  sleep_abort_a: assert property (!I_HW_SLEEP_INPUT_N [*3] |=> !O_BUSY &&
    $stable(O_TEMP_REMOTE) && $stable(O_TEMP_LOCAL)) else $error("cycle ran in standby");
  sw_abort_a: assert property (O_BUSY && $rose(I_SW_STANDBY) |=> !O_BUSY)
    else $error("software standby did not cut cycle");
endmodule
bind dtc_core dtc_core_checker u_dtc_core_checker (.I_REF_CLK, .I_SYS_RST,
  .I_HW_SLEEP_INPUT_N, .I_SW_STANDBY, .I_ONE_SHOT, .I_SDA_PULL, .O_SERIAL_DATA_LINE,
  .O_SERIAL_DATA_LINE_OE, .O_ALERT_N, .O_ALERT_N_OE, .O_BIAS_SEL, .O_ADDR_STRAP,
  .O_BUSY, .O_STANDBY, .O_TEMP_REMOTE, .O_TEMP_LOCAL, .O_ALARM_FLAGS);

// ==== tb/dtc_host_model.sv ====
// host side model: pulled-up wires, idle serial clock, standby pin
`timescale 1ns/100ps
module dtc_host_model (
  // device pins
  input  wire logic i_sda_oe,
  input  wire logic i_sda,
  input  wire logic i_alert_oe,
  input  wire logic i_alert,
  // host requests
  input  wire logic i_sleep_req,
  input  wire logic i_pull_sda,
  // resolved wires
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_alert,
  output logic      o_sleep_n
);
  // no frame is sent, so the serial clock stands high
  assign o_scl = 1'b1;
  // pull-up wins unless some party pulls low
  assign o_sda = !((i_sda_oe && !i_sda) || i_pull_sda);
  assign o_alert = !(i_alert_oe && !i_alert);
  // host selects standby by driving the pin low
  assign o_sleep_n = !i_sleep_req;
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench of the conversion controller
`timescale 1ns/100ps
module tb_top;
  // ---------------------------------------------------------------
  // stimulus and wires
  // ---------------------------------------------------------------
  logic clk = 0, rst = 1, alo = 0, ahi = 1, slp = 0, sw = 0, one = 0, aut = 0;
  logic hpull = 0, dpull = 0, lwe = 0;
  logic [1:0] lsel = 2'h3;
  logic [7:0] ldat = 8'h00;
  logic [8:0] rcode = 9'h0c9, lcode = 9'h1fb;
  logic scl, sda, alert, slp_n, sd_o, sd_oe, al_o, al_oe, busy, hw_sleep_input;
  logic [1:0] bias, strap, sync;
  logic [7:0] trem, tloc;
  logic [3:0] flags;
  int fail_count = 0, n_compared = 0;
  initial forever #50 clk = ~clk;
  dtc_host_model u_dtc_host_model (.i_sda_oe(sd_oe), .i_sda(sd_o), .i_alert_oe(al_oe),
    .i_alert(al_o), .i_sleep_req(slp), .i_pull_sda(hpull), .o_scl(scl), .o_sda(sda),
    .o_alert(alert), .o_sleep_n(slp_n));
  dtc_core #(.SETTLE_CYCLES(3), .INTEG_CYC(5)) u_dtc_core (.I_REF_CLK(clk),
    .I_SYS_RST(rst), .I_ADDR_SELECT_LOW_PIN(alo), .I_ADDR_SELECT_HIGH_PIN(ahi),
    .I_HW_SLEEP_INPUT_N(slp_n), .I_SERIAL_CLOCK_LINE(scl), .I_SERIAL_DATA_LINE(sda),
    .O_SERIAL_DATA_LINE(sd_o), .O_SERIAL_DATA_LINE_OE(sd_oe), .O_ALERT_N(al_o),
    .O_ALERT_N_OE(al_oe), .I_SW_STANDBY(sw), .I_ONE_SHOT(one), .I_AUTO_START(aut),
    .I_SDA_PULL(dpull), .I_LIMIT_WE(lwe), .I_LIMIT_SEL(lsel), .I_LIMIT_DATA(ldat),
    .I_ADC_CODE(bias == dtc_pkg::CH_REMOTE ? rcode : lcode), .O_BIAS_SEL(bias),
    .O_ADDR_STRAP(strap), .O_BUSY(busy), .O_STANDBY(hw_sleep_input), .O_TEMP_REMOTE(trem),
    .O_TEMP_LOCAL(tloc), .O_ALARM_FLAGS(flags), .O_SCL_SYNC_SDA_SYNC(sync));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // advance n edges, then drive just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  // compare one value, count it, report a mismatch
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // print counts and verdict, end the run
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one-cycle start pulse, one-shot or timer
  task automatic pulse(input bit timer);
    if (timer) aut = 1;
    else one = 1;
    step(1);
    aut = 0;
    one = 0;
  endtask
  // bounded wait for the cycle to end
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      step(1);
      n++;
    end
    if (busy !== 1'b0) begin
      fail_count++;
      close_out;
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    step(8);
    rst = 0;
    step(1);
    chk("busy", 8'h00, {7'h0, busy});
    step(6);
    chk("strap", 8'h02, {6'h0, strap});
    alo = 1;
    ahi = 0;
    step(6);
    chk("strap", 8'h02, {6'h0, strap});
    // one-shot: 100.5 rounds to 101, -2.5 rounds to -2
    pulse(0);
    chk("busy", 8'h01, {7'h0, busy});
    chk("bias", {6'h0, dtc_pkg::CH_REMOTE}, {6'h0, bias});
    step(8);
    chk("old remote", 8'h00, trem);
    wait_idle;
    chk("remote", 8'h65, trem);
    chk("local", 8'hfe, tloc);
    chk("flags", 8'h00, {4'h0, flags});
    // local low limit to 0 trips the alarm
    lwe = 1;
    step(1);
    lwe = 0;
    step(3);
    chk("flags", 8'h08, {4'h0, flags});
    chk("alert", 8'h00, {7'h0, alert});
    // standby pin mid-cycle aborts, data kept
    rcode = 9'h0ff;
    lcode = 9'h100;
    pulse(0);
    step(5);
    slp = 1;
    wait_idle;
    step(2);
    chk("remote", 8'h65, trem);
    chk("standby", 8'h01, {7'h0, hw_sleep_input});
    pulse(0);
    chk("busy", 8'h00, {7'h0, busy});
    step(20);
    chk("local", 8'hfe, tloc);
    // software standby: timer refused, one-shot runs, remote value clamps
    slp = 0;
    sw = 1;
    step(4);
    pulse(1);
    chk("busy", 8'h00, {7'h0, busy});
    pulse(0);
    chk("busy", 8'h01, {7'h0, busy});
    wait_idle;
    chk("remote", 8'h7f, trem);
    chk("local", 8'h80, tloc);
    // timer start, then software standby rises mid-cycle and cuts it
    sw = 0;
    rcode = 9'h0c9;
    step(2);
    pulse(1);
    chk("busy", 8'h01, {7'h0, busy});
    step(5);
    sw = 1;
    step(2);
    chk("busy", 8'h00, {7'h0, busy});
    chk("remote", 8'h7f, trem);
    sw = 0;
    wait_idle;
    // data line: host pulls, then device pulls
    hpull = 1;
    step(4);
    chk("sync", 8'h01, {6'h0, sync});
    hpull = 0;
    dpull = 1;
    step(4);
    chk("sync", 8'h01, {6'h0, sync});
    dpull = 0;
    step(2);
    close_out;
  end
endmodule
